// File: pkg/scwp_pkg.sv
// package: constants and carrier types of the serial configuration write port
package scwp_pkg;

  // ****************************************************
  // frame layout
  // ****************************************************
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned HDR_BITS     = 12;
  localparam int unsigned ADDR_BITS    = 4;
  localparam int unsigned DATA_BITS    = 16;
  localparam int unsigned CNT_W        = 5;
  localparam logic [11:0] HDR_PATTERN  = 12'h001;
  localparam logic [4:0]  LAST_BIT_IDX = 5'h1F;

  // ****************************************************
  // register addresses
  // ****************************************************
  localparam logic [3:0] ADDR_OUT_CFG   = 4'h1;
  localparam logic [3:0] ADDR_CH1_OFS   = 4'h2;
  localparam logic [3:0] ADDR_CH1_GAIN  = 4'h3;
  localparam logic [3:0] ADDR_CH2_OFS   = 4'hA;
  localparam logic [3:0] ADDR_CH2_GAIN  = 4'hB;
  localparam logic [3:0] ADDR_IL_EN     = 4'hD;
  localparam logic [3:0] ADDR_IL_COARSE = 4'hE;
  localparam logic [3:0] ADDR_IL_FINE   = 4'hF;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [15:0] RST_OUT_CFG   = 16'hB2FF;
  localparam logic [15:0] RST_CH1_OFS   = 16'h007F;
  localparam logic [15:0] RST_CH1_GAIN  = 16'h807F;
  localparam logic [15:0] RST_CH2_OFS   = 16'h007F;
  localparam logic [15:0] RST_CH2_GAIN  = 16'h807F;
  localparam logic [15:0] RST_IL_EN     = 16'h3FFF;
  localparam logic [15:0] RST_IL_COARSE = 16'h07FF;
  localparam logic [15:0] RST_IL_FINE   = 16'h007F;

  // ****************************************************
  // configuration field positions
  // ****************************************************
  localparam int unsigned CFG_DCS_BIT   = 12;
  localparam int unsigned CFG_DCP_BIT   = 11;
  localparam int unsigned CFG_SDR_BIT   = 10;
  localparam int unsigned CFG_AMP_BIT   = 9;
  localparam int unsigned CFG_EDGE_BIT  = 8;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] data;
  } scwp_wr_s;

  typedef struct packed {
    logic duty_stabilizer_enable;
    logic double_rate_clock_phase;
    logic single_rate_select;
    logic output_amplitude_select;
    logic edge_pin;
  } scwp_cfg_s;

  typedef struct packed {
    logic [15:0] output_configuration;
    logic [15:0] first_channel_offset;
    logic [15:0] first_channel_gain_adjust;
    logic [15:0] second_channel_offset;
    logic [15:0] second_channel_gain_adjust;
    logic [15:0] interleave_enable;
    logic [15:0] interleave_coarse_phase;
    logic [15:0] interleave_fine_phase;
  } scwp_regs_s;

endpackage : scwp_pkg

// File: verilog/scwp_sync2.sv
// module: two-flop level synchroniser
`timescale 1ns/1ns
module scwp_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // level
  input  wire logic i_d,
  output logic      o_q
);

  typedef struct packed {
    logic meta;
    logic q;
  } scwp_sync_s;

  scwp_sync_s st_q;
  scwp_sync_s st_d;

  always_comb begin
    st_d.meta = i_d;
    st_d.q    = st_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_q = st_q.q;

endmodule // scwp_sync2

// File: verilog/scwp_frame_rx.sv
// module: serial-clock domain frame shifter, emits a toggle per good frame
`timescale 1ns/1ns
module scwp_frame_rx (
  // serial clock domain
  input  wire logic              i_sclk,
  input  wire logic              i_rst_n,
  // serial lines
  input  wire logic              i_serial_select_n,
  input  wire logic              i_serial_data_in,
  input  wire logic              i_enable,
  // frame out
  output scwp_pkg::scwp_wr_s     o_wr,
  output logic                   o_wr_tgl
);

  typedef struct packed {
    logic [30:0]               shift;
    logic [scwp_pkg::CNT_W-1:0] cnt;
    scwp_pkg::scwp_wr_s        wr;
    logic                      tgl;
  } scwp_rx_s;

  scwp_rx_s st_q;
  scwp_rx_s st_d;
  logic [31:0] frame;

  always_comb begin
    st_d  = st_q;
    frame = {st_q.shift, i_serial_data_in};
    if (i_enable) begin
      st_d.shift = frame[30:0];
      st_d.cnt   = st_q.cnt + 5'h01; // wraps at 32: next frame at 33rd clock
      if (st_q.cnt == scwp_pkg::LAST_BIT_IDX) begin
        // header gate, address decoded downstream
        if (frame[31:20] == scwp_pkg::HDR_PATTERN) begin
          st_d.wr.addr = frame[19:16];
          st_d.wr.data = frame[15:0];
          st_d.tgl     = ~st_q.tgl;
        end
      end
    end
  end

  // select high clears count asynchronously: partial frame is dropped even
  // though sclk stops between frames
  always_ff @(posedge i_sclk or negedge i_rst_n or posedge i_serial_select_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else if (i_serial_select_n) begin
      st_q.cnt   <= 5'h00;
      st_q.shift <= 31'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_wr     = st_q.wr;
  assign o_wr_tgl = st_q.tgl;

endmodule // scwp_frame_rx

// File: verilog/scwp_top.sv
// module: serial configuration write port, top level
//
// Summary of operation
// - serial writes only in extended mode
// - data sampled on rising serial clock
// - frame is 32 bits, MSB first
// - header is eleven zeros then one
// - then 4 address bits, 16 data
// - next frame starts at 33rd clock
// - select held low permanently still works; here only after one release, as two clocks after reset go uncounted
// - decode the eight documented addresses
// - write-only; ignored in normal mode
// - bit 12 duty stabilizer, reset one
// - bit 11 double-rate clock phase
// - bit 10 single-rate select, reset zero
// - bit 9 output amplitude, reset one
// - bit 8 single-rate edge, reset zero
`timescale 1ns/1ns
module scwp_top (
  // system clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  // serial link
  input  wire logic                 i_serial_clk,
  input  wire logic                 i_serial_select_n,
  input  wire logic                 i_serial_data_in,
  // mode pins
  input  wire logic                 i_extended_mode_select_pin,
  input  wire logic                 i_amplitude_pin,
  input  wire logic                 i_edge_pin,
  input  wire logic                 i_single_rate_output,
  // effective output clocking controls
  output scwp_pkg::scwp_cfg_s       o_cfg,
  // register contents
  output scwp_pkg::scwp_regs_s      o_regs,
  // write strobe, one cycle per committed register
  output logic                      o_wr_pulse
);

  // ****************************************************
  // link side
  // ****************************************************
  logic               ext_link;
  scwp_pkg::scwp_wr_s link_wr;
  logic               link_tgl;

  // mode pin synchronised into the link domain as well
  scwp_sync2 #(
    .RST_VAL (1'b0)
  ) u_sync_mode_link (
    .i_clk   (i_serial_clk),
    .i_rst_n (i_rst_n),
    .i_d     (i_extended_mode_select_pin),
    .o_q     (ext_link)
  );

  scwp_frame_rx u_rx (
    .i_sclk            (i_serial_clk),
    .i_rst_n           (i_rst_n),
    .i_serial_select_n (i_serial_select_n),
    .i_serial_data_in  (i_serial_data_in),
    .i_enable          (ext_link),
    .o_wr              (link_wr),
    .o_wr_tgl          (link_tgl)
  );

  // ****************************************************
  // crossings into system clock
  // ****************************************************
  logic tgl_sys;
  logic ext_sys;
  logic amp_sys;
  logic edge_sys;
  logic sdr_sys;

  scwp_sync2 #(.RST_VAL(1'b0)) u_sync_tgl (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_d     (link_tgl),
    .o_q     (tgl_sys)
  );

  scwp_sync2 #(.RST_VAL(1'b0)) u_sync_ext (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_d     (i_extended_mode_select_pin),
    .o_q     (ext_sys)
  );

  scwp_sync2 #(.RST_VAL(1'b1)) u_sync_amp (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_d     (i_amplitude_pin),
    .o_q     (amp_sys)
  );

  scwp_sync2 #(.RST_VAL(1'b0)) u_sync_edge (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_d     (i_edge_pin),
    .o_q     (edge_sys)
  );

  scwp_sync2 #(.RST_VAL(1'b0)) u_sync_sdr (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_d     (i_single_rate_output),
    .o_q     (sdr_sys)
  );

  // ****************************************************
  // register file state
  // ****************************************************
  typedef struct packed {
    logic                 tgl_seen;
    logic [1:0]           capt;
    scwp_pkg::scwp_wr_s   wr;
    scwp_pkg::scwp_regs_s regs;
    scwp_pkg::scwp_cfg_s  cfg;
    logic                 wr_pulse;
  } scwp_top_s;

  scwp_top_s st_q;
  scwp_top_s st_d;
  logic [15:0] cfg_reg;

  // frame word is stable long before the toggle clears two flops here:
  // the toggle only changes after the 32nd edge and the word is held
  // until the next good frame, which is at least 32 serial clocks away
  always_comb begin
    st_d          = st_q;
    st_d.wr_pulse = 1'b0;
    st_d.capt     = {st_q.capt[0], 1'b0};
    if (tgl_sys != st_q.tgl_seen) begin
      st_d.tgl_seen = tgl_sys;
      st_d.capt     = {st_q.capt[0], 1'b1};
    end
    // one extra cycle lets the captured word settle before the decode
    if (st_q.capt[0]) begin
      st_d.wr = link_wr;
    end
    if (st_q.capt[1]) begin
      st_d.wr_pulse = 1'b1;
      if (st_q.wr.addr == scwp_pkg::ADDR_OUT_CFG) begin
        st_d.regs.output_configuration = st_q.wr.data;
      end else if (st_q.wr.addr == scwp_pkg::ADDR_CH1_OFS) begin
        st_d.regs.first_channel_offset = st_q.wr.data;
      end else if (st_q.wr.addr == scwp_pkg::ADDR_CH1_GAIN) begin
        st_d.regs.first_channel_gain_adjust = st_q.wr.data;
      end else if (st_q.wr.addr == scwp_pkg::ADDR_CH2_OFS) begin
        st_d.regs.second_channel_offset = st_q.wr.data;
      end else if (st_q.wr.addr == scwp_pkg::ADDR_CH2_GAIN) begin
        st_d.regs.second_channel_gain_adjust = st_q.wr.data;
      end else if (st_q.wr.addr == scwp_pkg::ADDR_IL_EN) begin
        st_d.regs.interleave_enable = st_q.wr.data;
      end else if (st_q.wr.addr == scwp_pkg::ADDR_IL_COARSE) begin
        st_d.regs.interleave_coarse_phase = st_q.wr.data;
      end else if (st_q.wr.addr == scwp_pkg::ADDR_IL_FINE) begin
        st_d.regs.interleave_fine_phase = st_q.wr.data;
      end else begin
        st_d.wr_pulse = 1'b0;
      end
    end

    // effective controls: registers only count in extended mode
    cfg_reg = st_d.regs.output_configuration;
    if (ext_sys) begin
      st_d.cfg.duty_stabilizer_enable  = cfg_reg[scwp_pkg::CFG_DCS_BIT];
      st_d.cfg.double_rate_clock_phase = cfg_reg[scwp_pkg::CFG_DCP_BIT]
                                         & ~cfg_reg[scwp_pkg::CFG_SDR_BIT];
      st_d.cfg.single_rate_select      = cfg_reg[scwp_pkg::CFG_SDR_BIT];
      st_d.cfg.output_amplitude_select = cfg_reg[scwp_pkg::CFG_AMP_BIT];
      st_d.cfg.edge_pin                = cfg_reg[scwp_pkg::CFG_EDGE_BIT]
                                         & cfg_reg[scwp_pkg::CFG_SDR_BIT];
    end else begin
      st_d.cfg.duty_stabilizer_enable  = 1'b1;
      st_d.cfg.double_rate_clock_phase = 1'b0;
      st_d.cfg.single_rate_select      = sdr_sys;
      st_d.cfg.output_amplitude_select = amp_sys;
      st_d.cfg.edge_pin                = edge_sys & sdr_sys;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q.tgl_seen <= 1'b0;
      st_q.capt     <= 2'h0;
      st_q.wr       <= '0;
      st_q.wr_pulse <= 1'b0;
      st_q.regs     <= {scwp_pkg::RST_OUT_CFG, scwp_pkg::RST_CH1_OFS,
                        scwp_pkg::RST_CH1_GAIN, scwp_pkg::RST_CH2_OFS,
                        scwp_pkg::RST_CH2_GAIN, scwp_pkg::RST_IL_EN,
                        scwp_pkg::RST_IL_COARSE, scwp_pkg::RST_IL_FINE};
      st_q.cfg      <= {scwp_pkg::RST_OUT_CFG[scwp_pkg::CFG_DCS_BIT],
                        scwp_pkg::RST_OUT_CFG[scwp_pkg::CFG_DCP_BIT]
                        & ~scwp_pkg::RST_OUT_CFG[scwp_pkg::CFG_SDR_BIT],
                        scwp_pkg::RST_OUT_CFG[scwp_pkg::CFG_SDR_BIT],
                        scwp_pkg::RST_OUT_CFG[scwp_pkg::CFG_AMP_BIT],
                        scwp_pkg::RST_OUT_CFG[scwp_pkg::CFG_EDGE_BIT]
                        & scwp_pkg::RST_OUT_CFG[scwp_pkg::CFG_SDR_BIT]};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_cfg      = st_q.cfg;
  assign o_regs     = st_q.regs;
  assign o_wr_pulse = st_q.wr_pulse;

endmodule // scwp_top

// File: bench/scwp_host.sv
// partner model: host side of the three-wire serial write port
`timescale 1ns/1ns
module scwp_host (
  // serial lines toward the device
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_sdat
);
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_sdat = 1'b1;
  end
  // no calibration is modelled, so no write can overlap one
  // clock runs only inside frames; data moves while it is low
  task automatic send(input logic [31:0] f, input int n, input bit keep);
    o_sel_n = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      o_sdat = f[i];
      #24 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
    end
    if (!keep) begin
      o_sel_n = 1'b1;
      o_sdat = ~o_sdat; // released line shows no stale bit
      // keep select high a while so a following frame sees a real release
      #24;
    end
  endtask
endmodule // scwp_host

// File: bench/scwp_top_chk.sv
// checker: port properties of the serial write port
`timescale 1ns/1ns
module scwp_top_chk (
  // clock and reset
  input wire logic            i_sys_clk,
  input wire logic            i_rst_n,
  // link and pins
  input wire logic            i_serial_select_n,
  input wire logic            i_extended_mode_select_pin,
  input wire logic            i_amplitude_pin,
  input wire logic            i_edge_pin,
  input wire logic            i_single_rate_output,
  // outputs watched
  input scwp_pkg::scwp_cfg_s  o_cfg,
  input scwp_pkg::scwp_regs_s o_regs,
  input wire logic            o_wr_pulse
);
  logic [15:0] c;
  logic [2:0]  pin;
  assign c = o_regs.output_configuration;
  assign pin = {i_single_rate_output, i_amplitude_pin, i_edge_pin};
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // synchronisers need a few cycles, hence the settled-mode prefix
  sequence s_ext; i_extended_mode_select_pin [*8]; endsequence
  property p_pls; o_wr_pulse |=> !o_wr_pulse; endproperty
  a_pls: assert property (p_pls) else $error("pulse too long");
  property p_chg; $changed(o_regs) |-> o_wr_pulse; endproperty
  a_chg: assert property (p_chg) else $error("silent change");
  property p_idl; i_serial_select_n [*8] |-> !o_wr_pulse; endproperty
  a_idl: assert property (p_idl) else $error("write while idle");
  property p_nrm; !i_extended_mode_select_pin |-> !o_wr_pulse; endproperty
  a_nrm: assert property (p_nrm) else $error("write in pin mode");
  property p_pin; (!i_extended_mode_select_pin && $stable(pin)) [*5] |->
    o_cfg == {2'b10, pin[2:1], pin[0] & pin[2]}; endproperty
  a_pin: assert property (p_pin) else $error("pin mode outputs");
  property p_dcs; s_ext |-> o_cfg.duty_stabilizer_enable == c[12]; endproperty
  a_dcs: assert property (p_dcs) else $error("stabilizer");
  property p_dcp; s_ext |-> o_cfg.double_rate_clock_phase == (c[11] & ~c[10]); endproperty
  a_dcp: assert property (p_dcp) else $error("clock phase");
  property p_sdr; s_ext |-> o_cfg.single_rate_select == c[10]; endproperty
  a_sdr: assert property (p_sdr) else $error("rate select");
  property p_amp; s_ext |-> o_cfg.output_amplitude_select == c[9]; endproperty
  a_amp: assert property (p_amp) else $error("amplitude");
  property p_edg; s_ext |-> o_cfg.edge_pin == (c[8] & c[10]); endproperty
  a_edg: assert property (p_edg) else $error("output edge");
  c_wr: cover property (o_wr_pulse);
  c_sdr: cover property (i_extended_mode_select_pin && o_cfg.single_rate_select);
  c_nrm: cover property (!i_extended_mode_select_pin && o_cfg.edge_pin);
endmodule // scwp_top_chk

bind scwp_top scwp_top_chk u_chk (.i_sys_clk, .i_rst_n, .i_serial_select_n,
  .i_extended_mode_select_pin, .i_amplitude_pin, .i_edge_pin, .i_single_rate_output,
  .o_cfg, .o_regs, .o_wr_pulse);

// File: bench/scwp_top_tb.sv
// testbench: random and corner frames through the serial write port
`timescale 1ns/1ns
module scwp_top_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b1;
  logic ext = 1'b1;
  logic [2:0] pin = 3'h2; // single rate, amplitude, edge
  logic sclk, sel_n, sdat, pulse;
  scwp_pkg::scwp_cfg_s cfg;
  scwp_pkg::scwp_regs_s regs;
  logic [7:0][15:0] er;
  logic [31:0] seed = 32'hE4069348;
  int error_cnt = 0, n_tests = 0, n_pulse = 0, x_pulse = 0;
  localparam logic [3:0] MAP [8] = '{scwp_pkg::ADDR_OUT_CFG, scwp_pkg::ADDR_CH1_OFS,
    scwp_pkg::ADDR_CH1_GAIN, scwp_pkg::ADDR_CH2_OFS, scwp_pkg::ADDR_CH2_GAIN,
    scwp_pkg::ADDR_IL_EN, scwp_pkg::ADDR_IL_COARSE, scwp_pkg::ADDR_IL_FINE};

  always #10 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) if (pulse === 1'b1) n_pulse++;

  scwp_host u_host (.o_sclk(sclk), .o_sel_n(sel_n), .o_sdat(sdat));
  scwp_top u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_serial_clk(sclk),
    .i_serial_select_n(sel_n), .i_serial_data_in(sdat), .i_extended_mode_select_pin(ext),
    .i_amplitude_pin(pin[1]), .i_edge_pin(pin[0]), .i_single_rate_output(pin[2]),
    .o_cfg(cfg), .o_regs(regs), .o_wr_pulse(pulse));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [4:0] xcfg();
    logic [15:0] c = er[7];
    if (!ext) return {2'b10, pin[2:1], pin[0] & pin[2]};
    return {c[12], c[11] & ~c[10], c[10], c[9], c[8] & c[10]};
  endfunction

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic verify(input string name);
    repeat (12) @(negedge i_sys_clk);
    check(128'(regs), 128'(er));
    check(128'(n_pulse), 128'(x_pulse));
    check(128'(cfg), 128'(xcfg()));
    $display("test %s done", name);
  endtask

  task automatic put(input logic [3:0] a, input logic [15:0] d, input bit keep, input int n);
    @(negedge i_sys_clk);
    u_host.send({scwp_pkg::HDR_PATTERN, a, d}, n, keep);
    for (int k = 0; k < 8; k++)
      if (MAP[k] == a && n == 32 && ext) begin
        er[7 - k] = d;
        x_pulse++;
      end
  endtask

  task automatic do_reset(input logic mode);
    @(negedge i_sys_clk);
    i_rst_n = 1'b0;
    ext = mode;
    repeat (4) @(negedge i_sys_clk);
    er = {scwp_pkg::RST_OUT_CFG, scwp_pkg::RST_CH1_OFS, scwp_pkg::RST_CH1_GAIN,
      scwp_pkg::RST_CH2_OFS, scwp_pkg::RST_CH2_GAIN, scwp_pkg::RST_IL_EN,
      scwp_pkg::RST_IL_COARSE, scwp_pkg::RST_IL_FINE};
    check(128'(regs), 128'(er));
    check(128'(cfg), 128'({er[7][12], er[7][11] & ~er[7][10], er[7][10], er[7][9],
      er[7][8] & er[7][10]}));
    i_rst_n = 1'b1;
    n_pulse = 0;
    x_pulse = 0;
    // a dropped three-bit stub also gives the mode sync its edges
    put(4'h1, 16'h0000, 1'b0, 3);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    logic [15:0] d;
    do_reset(1'b1);
    verify("reset");
    repeat (3) begin
      for (int a = 0; a < 16; a++) begin
        d = 16'(rnd());
        if (a == 1) d = {3'b101, d[12:9], d[8] & d[10], 8'hFF};
        put(4'(a), d, 1'b1, 32);
      end
      verify("sweep");
    end
    for (int k = 0; k < 8; k++) begin
      d = 16'(rnd());
      put(4'h1, {3'b101, k[0], k[1], k[2], d[0], k[2] & k[1], 8'hFF}, 1'b0, 32);
      verify("config");
    end
    u_host.send({12'h002, 4'h2, 16'hFFFF}, 32, 1'b0);
    u_host.send({12'h801, 4'h3, 16'h0000}, 32, 1'b0);
    verify("header");
    put(4'h2, 16'h1234, 1'b0, 20);
    put(4'h3, 16'h4321, 1'b0, 31);
    verify("abort");
    do_reset(1'b0);
    for (int k = 0; k < 8; k++) begin
      pin = 3'(k);
      put(MAP[k], 16'(rnd()), 1'b0, 32);
      verify("pin mode");
    end
    do_reset(1'b1);
    verify("rerun");
    give_verdict();
  end

  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end
endmodule // scwp_top_tb
